// file: hw/aux_mem_defines.svh
// constants for the auxiliary memory access block
// How it works
// - low 32 bytes: four register banks
// - bytes 20h to 2Fh are bit-addressable
// - addresses below 768 on-chip, rest external
// - 8-bit indirect moves reach low 256 only
// - only pointer moves reach 768 and above
// - external bus: port0, port2, two strobes
// - config bit 4 low blocks on-chip block
// - on-chip hits leave pins untouched
// - select bit chooses pointer 0 or 1
// - select bits 7..1 ignored, read zero
// - increment of select toggles pointer
// - six pointer instructions use selected pointer
// - pointer increment adds one over 16 bits
// - load immediate writes both pointer bytes
// - external move defaults to 3 cycles
// - larger stretch widens strobes and timing
// - clock control at 8Eh, resets to 01h
// - bit 5 sets timer 2 divide 12/4
// - bit 4 sets timer 1 divide 12/4
// - bit 3 sets timer 0 divide 12/4
// - bits 2..0 select stretch count
// - stretch gives 2..9 cycles, strobes 2..28
// - bank select maps registers in 8-byte steps
`ifndef AUX_MEM_DEFINES_SVH
`define AUX_MEM_DEFINES_SVH
`define SFR_PTR0_LOW 8'h82
`define SFR_PTR0_HIGH 8'h83
`define SFR_PTR1_LOW 8'h84
`define SFR_PTR1_HIGH 8'h85
`define SFR_PTR_SEL 8'h86
`define SFR_CLK_CTRL 8'h8E
`define CLK_CTRL_RESET 8'h01
`define CLK_CTRL_WMASK 8'h3F
`define TIMER2_FAST_BIT 5
`define TIMER1_FAST_BIT 4
`define TIMER0_FAST_BIT 3
`define AUX_ONCHIP_LIMIT 16'h0300
`define BITADDR_FIRST 8'h20
`define BITADDR_LAST 8'h2F
`define BANK_AREA_LAST 8'h1F
`define CFG_AUX_ENABLE_BIT 4
`define SLOW_DIVIDE 4'hC
`define FAST_DIVIDE 4'h4
`define SETUP_CLOCKS 8'h02
`define HOLD_CLOCKS 8'h02
`endif

// file: hw/aux_mem_pkg.sv
// types for the auxiliary memory access block
package aux_mem_pkg;
  typedef enum logic [2:0] {
    PTR_NONE = 3'h0,
    PTR_INC = 3'h1,
    PTR_LOAD = 3'h2,
    PTR_CODE = 3'h3,
    PTR_READ = 3'h4,
    PTR_WRITE = 3'h5,
    PTR_JUMP = 3'h6,
    RI_READ = 3'h7
  } op_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_SETUP = 2'h1,
    BUS_STROBE = 2'h2,
    BUS_HOLD = 2'h3
  } bus_state_t;
  // one external-move or pointer request from the core
  typedef struct packed {
    logic valid;
    op_t op;
    logic riWrite;
    logic [7:0] riAddr;
    logic [15:0] imm;
    logic [7:0] wdata;
  } move_req_t;
  // pins of the multiplexed external bus
  typedef struct packed {
    logic [7:0] port0Out;
    logic port0Oe;
    logic [7:0] port2Out;
    logic writeStrobeN;
    logic readStrobeN;
  } ext_bus_t;
endpackage

// file: hw/aux_memory_external_move_access.sv
// data pointers, clock control and external move engine
`timescale 1ns/10ps
`include "aux_mem_defines.svh"
module aux_memory_external_move_access
  import aux_mem_pkg::*;
(
  input wire logic core_clk, // cpu clock
  input wire logic srst, // sync reset, high
  input wire logic sfrWe, // sfr write strobe
  input wire logic sfrRe, // sfr read strobe
  input wire logic [7:0] sfrAddr, // sfr address
  input wire logic [7:0] sfrWdata, // sfr write data
  output logic [7:0] sfrRdata_r, // sfr read data
  input wire logic [7:0] programStatusWord, // bank select in 4:3
  input wire logic [7:0] chipConfigReg, // bit 4 enables aux
  input wire logic runInternal, // code from internal memory
  input wire logic [7:0] ramAddr, // internal ram address
  input wire move_req_t req, // move request
  output logic busy_r, // move in progress
  output logic done_r, // move done pulse
  output logic [7:0] rdata_r, // move read data
  output logic [15:0] activeDataPointer_r, // selected pointer
  output logic [4:0] bankRegAddr_r, // working register address
  output logic bitAddressable_r, // ram address is bit space
  output logic timer0Tick_r, // timer 0 clock enable
  output logic timer1Tick_r, // timer 1 clock enable
  output logic timer2Tick_r, // timer 2 clock enable
  output ext_bus_t bus_r, // external bus pins
  input wire logic [7:0] port0In // port 0 pin input
);
  logic [15:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt;
  logic sel_r, sel_nxt;
  logic [7:0] clkCtrl_r, clkCtrl_nxt;
  logic [7:0] auxMem [0:767];
  logic [7:0] port0Sync1_r, port0Sync2_r;
  bus_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic isWrite_r, isWrite_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [7:0] rd_nxt;
  logic done_nxt;
  ext_bus_t bus_nxt;
  logic [3:0] div12_r, div12_nxt;
  logic [1:0] div4_r, div4_nxt;
  logic [7:0] rdNxt;
  logic auxWe;
  logic [9:0] auxIdx;
  logic [7:0] auxWd;
  logic [15:0] selPtr;
  logic onChip;
  logic auxOk;
  logic [15:0] reqAddr;

  // strobe width in cpu clocks for a stretch code
  function automatic logic [7:0] strobeClocks(input logic [2:0] code);
    strobeClocks = (code == 3'h0) ? 8'h02 : {3'h0, code, 2'h0};
  endfunction

  // true when an aux address hits the on-chip block
  function automatic logic isOnChip(input logic [15:0] a);
    isOnChip = a < `AUX_ONCHIP_LIMIT;
  endfunction

  assign selPtr = sel_r ? ptr1_r : ptr0_r;
  assign auxOk = chipConfigReg[`CFG_AUX_ENABLE_BIT];
  // 8-bit indirect form covers only the low 256 bytes
  assign reqAddr = (req.op == RI_READ) ? {8'h00, req.riAddr} : selPtr;
  assign onChip = isOnChip(reqAddr);

  // pointer, select and clock control next values
  always_comb begin
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    sel_nxt = sel_r;
    clkCtrl_nxt = clkCtrl_r;
    if (sfrWe) begin
      unique case (sfrAddr)
        `SFR_PTR0_LOW: ptr0_nxt[7:0] = sfrWdata;
        `SFR_PTR0_HIGH: ptr0_nxt[15:8] = sfrWdata;
        `SFR_PTR1_LOW: ptr1_nxt[7:0] = sfrWdata;
        `SFR_PTR1_HIGH: ptr1_nxt[15:8] = sfrWdata;
        // increment of the select register lands here as old+1
        `SFR_PTR_SEL: sel_nxt = sfrWdata[0];
        `SFR_CLK_CTRL: clkCtrl_nxt = sfrWdata & `CLK_CTRL_WMASK;
        default: ;
      endcase
    end
    if (req.valid && state_r == BUS_IDLE && !busy_r) begin
      if (req.op == PTR_INC) begin
        if (sel_r) ptr1_nxt = ptr1_r + 16'h0001;
        else ptr0_nxt = ptr0_r + 16'h0001;
      end else if (req.op == PTR_LOAD) begin
        if (sel_r) ptr1_nxt = req.imm;
        else ptr0_nxt = req.imm;
      end
    end
  end

  // sfr read mux
  always_comb begin
    unique case (sfrAddr)
      `SFR_PTR0_LOW: rdNxt = ptr0_r[7:0];
      `SFR_PTR0_HIGH: rdNxt = ptr0_r[15:8];
      `SFR_PTR1_LOW: rdNxt = ptr1_r[7:0];
      `SFR_PTR1_HIGH: rdNxt = ptr1_r[15:8];
      `SFR_PTR_SEL: rdNxt = {7'h00, sel_r};
      `SFR_CLK_CTRL: rdNxt = clkCtrl_r;
      default: rdNxt = 8'h00;
    endcase
  end

  // timer prescalers: shared divide-by-12 and divide-by-4 enables
  always_comb begin
    div12_nxt = (div12_r == `SLOW_DIVIDE - 4'h1) ? 4'h0 : div12_r + 4'h1;
    div4_nxt = div4_r + 2'h1;
  end

  // external move sequencer and on-chip access
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    isWrite_nxt = isWrite_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rdata_r;
    done_nxt = 1'b0;
    bus_nxt = bus_r;
    auxWe = 1'b0;
    auxIdx = reqAddr[9:0];
    auxWd = req.op == RI_READ ? req.wdata : req.wdata;
    unique case (state_r)
      BUS_IDLE: begin
        if (req.valid && !busy_r && (req.op == PTR_READ ||
            req.op == PTR_WRITE || req.op == RI_READ)) begin
          isWrite_nxt = req.op == PTR_WRITE ||
                        (req.op == RI_READ && req.riWrite);
          if (onChip) begin
            // on-chip hit leaves the pins as they were
            if (auxOk) begin
              auxWe = isWrite_nxt;
              rd_nxt = auxMem[auxIdx];
            end else begin
              rd_nxt = 8'h00;
            end
            done_nxt = 1'b1;
          end else begin
            // address phase: low byte on port 0, high byte on port 2
            addr_nxt = reqAddr;
            wd_nxt = req.wdata;
            bus_nxt.port0Out = reqAddr[7:0];
            bus_nxt.port0Oe = 1'b1;
            bus_nxt.port2Out = reqAddr[15:8];
            cnt_nxt = `SETUP_CLOCKS - 8'h01;
            state_nxt = BUS_SETUP;
          end
        end else if (req.valid && !busy_r && req.op != PTR_NONE) begin
          // pointer-only ops finish in one cycle
          done_nxt = 1'b1;
        end
      end
      BUS_SETUP: begin
        if (cnt_r == 8'h00) begin
          bus_nxt.port0Out = wd_r;
          bus_nxt.port0Oe = isWrite_r;
          bus_nxt.writeStrobeN = !isWrite_r;
          bus_nxt.readStrobeN = isWrite_r;
          cnt_nxt = strobeClocks(clkCtrl_r[2:0]) - 8'h01;
          state_nxt = BUS_STROBE;
        end else cnt_nxt = cnt_r - 8'h01;
      end
      BUS_STROBE: begin
        bus_nxt.port2Out = addr_r[15:8];
        if (cnt_r == 8'h00) begin
          bus_nxt.writeStrobeN = 1'b1;
          bus_nxt.readStrobeN = 1'b1;
          cnt_nxt = `HOLD_CLOCKS - 8'h01;
          state_nxt = BUS_HOLD;
        end else cnt_nxt = cnt_r - 8'h01;
      end
      BUS_HOLD: begin
        // synchroniser lags two clocks: take read data in first hold clock
        if (cnt_r == `HOLD_CLOCKS - 8'h01 && !isWrite_r)
          rd_nxt = port0Sync2_r;
        if (cnt_r == 8'h00) begin
          bus_nxt.port0Oe = 1'b0;
          done_nxt = 1'b1;
          state_nxt = BUS_IDLE;
        end else cnt_nxt = cnt_r - 8'h01;
      end
      default: state_nxt = BUS_IDLE;
    endcase
  end

  // register all state
  always_ff @(posedge core_clk) begin
    port0Sync1_r <= port0In;
    port0Sync2_r <= port0Sync1_r;
    if (auxWe) auxMem[auxIdx] <= auxWd;
    if (srst) begin
      ptr0_r <= 16'h0000;
      ptr1_r <= 16'h0000;
      sel_r <= 1'b0;
      clkCtrl_r <= `CLK_CTRL_RESET;
      state_r <= BUS_IDLE;
      cnt_r <= 8'h00;
      isWrite_r <= 1'b0;
      addr_r <= 16'h0000;
      wd_r <= 8'h00;
      rdata_r <= 8'h00;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      bus_r <= '{port0Out: 8'hFF, port0Oe: 1'b0, port2Out: 8'hFF,
                 writeStrobeN: 1'b1, readStrobeN: 1'b1};
      sfrRdata_r <= 8'h00;
      activeDataPointer_r <= 16'h0000;
      bankRegAddr_r <= 5'h00;
      bitAddressable_r <= 1'b0;
      div12_r <= 4'h0;
      div4_r <= 2'h0;
      timer0Tick_r <= 1'b0;
      timer1Tick_r <= 1'b0;
      timer2Tick_r <= 1'b0;
    end else begin
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      sel_r <= sel_nxt;
      clkCtrl_r <= clkCtrl_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      isWrite_r <= isWrite_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rdata_r <= rd_nxt;
      done_r <= done_nxt;
      busy_r <= state_nxt != BUS_IDLE;
      bus_r <= bus_nxt;
      sfrRdata_r <= sfrRe ? rdNxt : 8'h00;
      activeDataPointer_r <= sel_nxt ? ptr1_nxt : ptr0_nxt;
      // working register: bank bits 4:3 above register number
      bankRegAddr_r <= {programStatusWord[4:3], ramAddr[2:0]};
      bitAddressable_r <= ramAddr >= `BITADDR_FIRST &&
                          ramAddr <= `BITADDR_LAST;
      div12_r <= div12_nxt;
      div4_r <= div4_nxt;
      timer2Tick_r <= clkCtrl_r[`TIMER2_FAST_BIT] ? div4_r == 2'h3 :
                      div12_r == 4'hB;
      timer1Tick_r <= clkCtrl_r[`TIMER1_FAST_BIT] ? div4_r == 2'h3 :
                      div12_r == 4'hB;
      timer0Tick_r <= clkCtrl_r[`TIMER0_FAST_BIT] ? div4_r == 2'h3 :
                      div12_r == 4'hB;
    end
  end

  // checks
  // select write keeps bit 0 only
  a_sel_write_bit: assert property (@(posedge core_clk) disable iff (srst)
    sfrWe && sfrAddr == `SFR_PTR_SEL |=> sel_r == $past(sfrWdata[0]))
    else $error("select write wrong");

  // clock control write lands masked
  a_clk_ctrl_write: assert property (@(posedge core_clk) disable iff (srst)
    sfrWe && sfrAddr == `SFR_CLK_CTRL
    |=> clkCtrl_r == ($past(sfrWdata) & `CLK_CTRL_WMASK))
    else $error("clock control write wrong");

  // pointer 0 high byte reads back
  a_ptr_read_back: assert property (@(posedge core_clk) disable iff (srst)
    sfrRe && sfrAddr == `SFR_PTR0_HIGH |=> sfrRdata_r == $past(ptr0_r[15:8]))
    else $error("pointer read back wrong");

  // increment of pointer 0 leaves pointer 1 alone
  a_inc_keeps_other: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && req.op == PTR_INC && !busy_r && !sfrWe && !sel_r
    |=> ptr1_r == $past(ptr1_r))
    else $error("increment hit other pointer");

  // load into pointer 1 leaves pointer 0 alone
  a_load_keeps_other: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && req.op == PTR_LOAD && !busy_r && !sfrWe && sel_r
    |=> ptr0_r == $past(ptr0_r))
    else $error("load hit other pointer");

  // on-chip moves finish at once
  a_onchip_done: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && !busy_r && onChip && (req.op == PTR_READ ||
    req.op == PTR_WRITE || req.op == RI_READ) |=> done_r && !busy_r)
    else $error("on-chip move not done");

  // indirect form never leaves the chip
  a_ri_local: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && !busy_r && req.op == RI_READ |=> !busy_r)
    else $error("indirect move went external");

  // external pointer move drives the low address
  a_ext_start: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && !busy_r && !onChip && (req.op == PTR_READ ||
    req.op == PTR_WRITE) |=> busy_r && bus_r.port0Oe &&
    bus_r.port0Out == $past(selPtr[7:0]))
    else $error("external address phase wrong");

  // external pointer move drives the high address
  a_ext_high_byte: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && !busy_r && !onChip && (req.op == PTR_READ ||
    req.op == PTR_WRITE) |=> bus_r.port2Out == $past(selPtr[15:8]))
    else $error("external high address wrong");

  // blocked on-chip block reads zero
  a_cfg_blocks: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && !busy_r && req.op == RI_READ && !req.riWrite && !auxOk
    |=> rdata_r == 8'h00)
    else $error("blocked read not zero");

  // write strobe carries driven data
  a_wr_data_out: assert property (@(posedge core_clk) disable iff (srst)
    !bus_r.writeStrobeN |-> bus_r.port0Oe && bus_r.port0Out == wd_r)
    else $error("write data not driven");

  // read strobe leaves port 0 to the memory
  a_rd_p0_free: assert property (@(posedge core_clk) disable iff (srst)
    !bus_r.readStrobeN |-> !bus_r.port0Oe)
    else $error("port 0 driven during read");

  // never both strobes at once
  a_strobes_apart: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |-> bus_r.writeStrobeN || bus_r.readStrobeN)
    else $error("both strobes low");

  // bit-addressable flag follows the address
  a_bit_space: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> bitAddressable_r == ($past(ramAddr) >= `BITADDR_FIRST &&
    $past(ramAddr) <= `BITADDR_LAST))
    else $error("bit space flag wrong");

  // timer 1 fast ticks spaced by four
  a_fast_tick1: assert property (@(posedge core_clk) disable iff (srst)
    timer1Tick_r && clkCtrl_r[`TIMER1_FAST_BIT] && $stable(clkCtrl_r)
    |=> !timer1Tick_r [*3])
    else $error("timer 1 tick spacing");

  // timer 2 fast ticks spaced by four
  a_fast_tick2: assert property (@(posedge core_clk) disable iff (srst)
    timer2Tick_r && clkCtrl_r[`TIMER2_FAST_BIT] && $stable(clkCtrl_r)
    |=> !timer2Tick_r [*3])
    else $error("timer 2 tick spacing");

  // external move ends after the hold clocks
  a_ext_done: assert property (@(posedge core_clk) disable iff (srst)
    state_r == BUS_HOLD && cnt_r == 8'h00 |=> done_r && !busy_r)
    else $error("external move not done");

  // default stretch gives a four-clock strobe
  a_width_default: assert property (@(posedge core_clk) disable iff (srst)
    $fell(bus_r.writeStrobeN) && clkCtrl_r[2:0] == 3'h1
    |-> !bus_r.writeStrobeN [*4] ##1 bus_r.writeStrobeN)
    else $error("default strobe width wrong");

  // largest stretch gives a 28-clock strobe
  a_width_max: assert property (@(posedge core_clk) disable iff (srst)
    $fell(bus_r.readStrobeN) && clkCtrl_r[2:0] == 3'h7
    |-> ##27 !bus_r.readStrobeN ##1 bus_r.readStrobeN)
    else $error("longest strobe width wrong");

  a_sel_reads_zero: assert property (@(posedge core_clk) disable iff (srst)
    sfrRe && sfrAddr == `SFR_PTR_SEL |=> sfrRdata_r[7:1] == 7'h00)
    else $error("select upper bits not zero");
  a_ptr_inc_one: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && req.op == PTR_INC && !busy_r && !sfrWe && !sel_r
    |=> ptr0_r == $past(ptr0_r) + 16'h0001)
    else $error("pointer increment wrong");
  a_ptr_load_imm: assert property (@(posedge core_clk) disable iff (srst)
    req.valid && req.op == PTR_LOAD && !busy_r && !sfrWe
    |=> activeDataPointer_r == $past(req.imm))
    else $error("pointer load wrong");
  a_onchip_quiet: assert property (@(posedge core_clk) disable iff (srst)
    state_r == BUS_IDLE && !busy_r && req.valid && onChip && runInternal
    |=> bus_r == $past(bus_r))
    else $error("on-chip access moved pins");
  a_strobe_hi_stable: assert property (@(posedge core_clk) disable iff (srst)
    !bus_r.readStrobeN |=> bus_r.port2Out == $past(bus_r.port2Out))
    else $error("high address moved");
  a_strobe_two_min: assert property (@(posedge core_clk) disable iff (srst)
    $fell(bus_r.readStrobeN) |-> !bus_r.readStrobeN [*2])
    else $error("strobe too short");
  a_strobe_width: assert property (@(posedge core_clk) disable iff (srst)
    $fell(bus_r.writeStrobeN) |-> ##[1:28] bus_r.writeStrobeN)
    else $error("strobe too long");
  a_fast_tick: assert property (@(posedge core_clk) disable iff (srst)
    timer0Tick_r && clkCtrl_r[`TIMER0_FAST_BIT] && $stable(clkCtrl_r)
    |=> !timer0Tick_r [*3])
    else $error("timer 0 tick spacing");
  a_bank_map: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> bankRegAddr_r[4:3] == $past(programStatusWord[4:3]))
    else $error("bank mapping wrong");
endmodule

// file: dv/ext_mem_model.sv
// external data memory model on the multiplexed bus
`timescale 1ns/10ps
module ext_mem_model
  import aux_mem_pkg::*;
(
  input wire logic core_clk, // cpu clock
  input wire ext_bus_t bus, // bus pins from the block
  output logic [7:0] port0In // port 0 pin level
);
  logic [7:0] mem [0:65535];
  logic [7:0] addrLo;
  logic [7:0] last = 8'h00;
  logic oePrev = 1'b0;
  // latch low address at setup, store bytes under write strobe
  always @(posedge core_clk) begin
    oePrev <= bus.port0Oe;
    last <= port0In;
    if (bus.port0Oe && !oePrev && bus.readStrobeN && bus.writeStrobeN) begin
      addrLo <= bus.port0Out;
    end
    if (!bus.writeStrobeN) begin
      mem[{bus.port2Out, addrLo}] <= bus.port0Out;
    end
  end
  // data only under read strobe, a changing pattern when released
  assign port0In = !bus.readStrobeN ? mem[{bus.port2Out, addrLo}] : ~last;
endmodule

// file: dv/tb.sv
// self-checking bench for the auxiliary memory access block
`timescale 1ns/10ps
module tb;
  import aux_mem_pkg::*;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] addr;
    logic [4:0] bank;
    logic bitA;
  } row_t;
  localparam row_t ROWS [8] = '{'{8'h00, 8'h05, 5'h05, 1'b0},
    '{8'h08, 8'h0B, 5'h0B, 1'b0}, '{8'h10, 8'h17, 5'h17, 1'b0},
    '{8'h18, 8'h1F, 5'h1F, 1'b0}, '{8'h18, 8'h20, 5'h18, 1'b1},
    '{8'h00, 8'h2F, 5'h07, 1'b1}, '{8'h00, 8'h30, 5'h00, 1'b0},
    '{8'h08, 8'h1F, 5'h0F, 1'b0}};
  logic core_clk = 0, srst = 1, sfrWe = 0, sfrRe = 0, runInternal = 1;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, programStatusWord = 8'h00;
  logic [7:0] chipConfigReg = 8'h10, ramAddr = 8'h00, sfrRdata_r, rdata_r;
  move_req_t req = '0;
  logic busy_r, done_r, bitAddressable_r;
  logic timer0Tick_r, timer1Tick_r, timer2Tick_r;
  logic [15:0] activeDataPointer_r;
  logic [4:0] bankRegAddr_r;
  ext_bus_t bus_r;
  logic [7:0] port0In, d, expHigh = 8'hFF;
  int failures = 0, compares = 0, lowCnt = 0, p2Bad = 0, i, n0, n1, n2;
  always #20 core_clk = ~core_clk;
  aux_memory_external_move_access dut (.core_clk, .srst, .sfrWe, .sfrRe, .sfrAddr,
    .sfrWdata, .sfrRdata_r, .programStatusWord, .chipConfigReg,
    .runInternal, .ramAddr, .req, .busy_r, .done_r, .rdata_r,
    .activeDataPointer_r, .bankRegAddr_r, .bitAddressable_r,
    .timer0Tick_r, .timer1Tick_r, .timer2Tick_r, .bus_r, .port0In);
  ext_mem_model mem (.core_clk, .bus(bus_r), .port0In);
  // strobe width and steadiness of the high address byte
  always @(posedge core_clk) begin
    if (!bus_r.readStrobeN || !bus_r.writeStrobeN) begin
      lowCnt <= lowCnt + 1;
      if (bus_r.port2Out !== expHigh) p2Bad <= p2Bad + 1;
    end
  end
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfrWe <= 1'b1;
    sfrAddr <= a;
    sfrWdata <= v;
    @(posedge core_clk);
    sfrWe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    sfrRe <= 1'b1;
    sfrAddr <= a;
    @(posedge core_clk);
    sfrRe <= 1'b0;
    #1;
    v = sfrRdata_r;
  endtask
  task mv(input op_t op, input logic w, input logic [7:0] ra,
    input logic [15:0] im, input logic [7:0] wd);
    int k;
    lowCnt = 0;
    p2Bad = 0;
    @(posedge core_clk);
    req <= '{valid: 1'b1, op: op, riWrite: w, riAddr: ra, imm: im, wdata: wd};
    for (k = 0; k < 400; k++) begin
      @(posedge core_clk);
      if (k == 0) req.valid <= 1'b0;
      #1;
      if (done_r === 1'b1) break;
    end
    cmp({15'h0, done_r}, 16'h1);
  endtask
  task give_verdict;
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #(40 * 5000);
    failures++;
    give_verdict;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd((i < 5) ? 8'h82 + 8'(i) : 8'h8E, d);
      cmp(d, (i < 5) ? 16'h0 : 16'h1);
    end
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk);
      programStatusWord <= ROWS[i].status;
      ramAddr <= ROWS[i].addr;
      @(posedge core_clk);
      #1;
      cmp(bankRegAddr_r, ROWS[i].bank);
      cmp(bitAddressable_r, ROWS[i].bitA);
    end
    wr(8'h86, 8'hFF);
    rd(8'h86, d);
    cmp(d, 16'h1);
    wr(8'h86, d + 8'h01);
    rd(8'h86, d);
    cmp(d, 16'h0);
    mv(PTR_LOAD, 0, 8'h00, 16'h12FF, 8'h00);
    cmp(activeDataPointer_r, 16'h12FF);
    rd(8'h83, d);
    cmp(d, 16'h12);
    mv(PTR_INC, 0, 8'h00, 16'h0000, 8'h00);
    cmp(activeDataPointer_r, 16'h1300);
    wr(8'h86, 8'h01);
    rd(8'h82, d);
    cmp(activeDataPointer_r, 16'h0000);
    mv(PTR_LOAD, 0, 8'h00, 16'h0305, 8'h00);
    rd(8'h85, d);
    cmp(d, 16'h03);
    mv(PTR_CODE, 0, 8'h00, 16'h0000, 8'h00);
    mv(PTR_JUMP, 0, 8'h00, 16'h0000, 8'h00);
    cmp(activeDataPointer_r, 16'h0305);
    mv(RI_READ, 1, 8'h10, 16'h0000, 8'h5A);
    cmp(bus_r.port2Out, 16'hFF);
    cmp({bus_r.writeStrobeN, bus_r.readStrobeN}, 16'h3);
    mv(RI_READ, 0, 8'h10, 16'h0000, 8'h00);
    cmp(rdata_r, 16'h5A);
    wr(8'h86, 8'h00);
    mv(PTR_LOAD, 0, 8'h00, 16'h0010, 8'h00);
    mv(PTR_READ, 0, 8'h00, 16'h0000, 8'h00);
    cmp(rdata_r, 16'h5A);
    @(posedge core_clk);
    chipConfigReg <= 8'h00;
    mv(RI_READ, 1, 8'h10, 16'h0000, 8'h77);
    mv(RI_READ, 0, 8'h10, 16'h0000, 8'h00);
    cmp(rdata_r, 16'h00);
    chipConfigReg <= 8'h10;
    mv(RI_READ, 0, 8'h10, 16'h0000, 8'h00);
    cmp(rdata_r, 16'h5A);
    wr(8'h86, 8'h01);
    expHigh = 8'h03;
    mv(PTR_WRITE, 0, 8'h00, 16'h0000, 8'hA5);
    cmp(lowCnt, 16'h4);
    cmp(p2Bad, 16'h0);
    for (i = 0; i < 8; i++) begin
      wr(8'h8E, 8'(i));
      mv(PTR_READ, 0, 8'h00, 16'h0000, 8'h00);
      cmp(lowCnt, (i == 0) ? 16'h2 : 16'(4 * i));
      cmp(rdata_r, 16'hA5);
      cmp(p2Bad, 16'h0);
    end
    wr(8'h8E, 8'hFF);
    rd(8'h8E, d);
    cmp(d, 16'h3F);
    for (i = 3; i < 6; i++) begin
      wr(8'h8E, 8'h01 | (8'h01 << i));
      repeat (12) @(posedge core_clk);
      n0 = 0;
      n1 = 0;
      n2 = 0;
      repeat (24) begin
        @(posedge core_clk);
        #1;
        n0 += int'(timer0Tick_r);
        n1 += int'(timer1Tick_r);
        n2 += int'(timer2Tick_r);
      end
      cmp(n0, (i == 3) ? 16'h6 : 16'h2);
      cmp(n1, (i == 4) ? 16'h6 : 16'h2);
      cmp(n2, (i == 5) ? 16'h6 : 16'h2);
    end
    give_verdict;
  end
endmodule
